/* File: common/timer_params.svh */
// offsets, field positions, reset values and counts of the timer register set
// assumes a 12-bit apb byte address, one aligned 32-bit word per register
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ----------------------------------------------------------------------------
// register word indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define APB_ADDR_W 12
`define IDX_W 10
`define IDX_CONTROL 10'h0c8
`define IDX_MODE 10'h0c9
`define IDX_RCAP_LOW 10'h0ca
`define IDX_RCAP_HIGH 10'h0cb
`define IDX_COUNT_LOW 10'h0cc
`define IDX_COUNT_HIGH 10'h0cd
`define IDX_IRQ_STATUS 10'h0d0
`define IDX_IRQ_MASK 10'h0d1

// ----------------------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------------------
`define RST_CONTROL 8'h00
`define RST_MODE 8'h00
`define RST_DATA 8'h00
`define RST_IRQ 2'h0
`define MODE_WRITE_MASK 8'h83

// ----------------------------------------------------------------------------
// interrupt status bit positions
// ----------------------------------------------------------------------------
`define IRQ_BITS 2
`define IRQ_BIT_OVERFLOW 0
`define IRQ_BIT_EXTERNAL 1

// ----------------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------------
`define PRESCALE_DIV 12
`define COUNT_TOP 16'hffff

`endif

/* File: common/timer_pkg.sv */
// types of the timer register set: register layouts and operating modes
// assumes the offsets and reset values of timer_params.svh
package timer_pkg;

  // --------------------------------------------------------------------------
  // register layouts
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic overflow_flag;
    logic external_event_flag;
    logic receive_clock_select;
    logic transmit_clock_select;
    logic external_trigger_enable;
    logic run_control;
    logic timer_counter_select;
    logic capture_reload_select;
  } control_t;

  typedef struct packed {
    logic prescaler_select;
    logic [4:0] reserved;
    logic clock_output_enable;
    logic down_count_enable;
  } mode_reg_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } word16_t;

  // --------------------------------------------------------------------------
  // operating modes
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    MODE_CAPTURE = 5'b00001,
    MODE_RELOAD = 5'b00010,
    MODE_UPDOWN = 5'b00100,
    MODE_BAUD = 5'b01000,
    MODE_CLKOUT = 5'b10000
  } op_mode_t;

endpackage : timer_pkg

/* File: hdl/pin_sync.sv */
// two-flop synchroniser for one pin input
// assumes the pin is asynchronous to clk
`timescale 1ns/100ps

module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pin,
  output logic level
);

  logic meta;
  logic next_meta;
  logic next_level;

  always_comb
  begin
    next_meta = pin;
    next_level = meta;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta <= RESET_LEVEL;
      level <= RESET_LEVEL;
    end
    else
    begin
      meta <= next_meta;
      level <= next_level;
    end
  end

endmodule : pin_sync

/* File: hdl/timer2_control_registers.sv */
// 16-bit timer/counter with capture, reload, up/down, baud and clock-out modes
// assumes an apb master on CLK and asynchronous count and trigger pins
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
`include "timer_params.svh"

// How it works
// - run bit zero halts the count; one lets it advance on the input
// - select bit zero counts internal clock; count pin stays a port pin
// - select bit one counts count pin falling edges and enables its pull-up
// - capture/reload bit picks reload at zero, capture at one
// - prescaler bit zero gives clock over twelve, one gives full clock
// - output enable one drives the shared pin; generated clock toggles on it only with select bit zero
// - down-count enable zero counts up only; one allows both directions
// - receive select one makes serial receive baud come from this timer
// - low and high reload/capture bytes are software readable and writable
// - low and high live count bytes are software readable and writable
// - receive and transmit baud selects are independent bits
// - hardware sets both flags and toggles the external flag on each up/down wrap; software sets or clears; reset clears
// - capture mode with trigger enable: trigger falling edge captures, sets flag
// - up/down mode: trigger high counts up, trigger low counts down
// - either baud select gives baud mode: overflow reloads, no overflow flag
module timer2_control_registers
  import timer_pkg::*;
#(
  parameter int PRESCALE_DIV = `PRESCALE_DIV
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`APB_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic COUNT_PIN_I,
  output logic COUNT_PIN_O,
  output logic COUNT_PIN_OE,
  output logic COUNT_PIN_PULLUP,
  input wire logic TRIG_PIN_I,
  output logic RX_BAUD_SELECT,
  output logic TX_BAUD_SELECT,
  output logic BAUD_TICK,
  output logic IRQ
);

  // --------------------------------------------------------------------------
  // parameter check
  // --------------------------------------------------------------------------
  localparam int PW = (PRESCALE_DIV > 2) ? $clog2(PRESCALE_DIV) : 1;

  generate
    if (PRESCALE_DIV < 2 || PRESCALE_DIV > 256)
    begin : bad_prescale
      $error("prescale divider out of range");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  control_t ctrl;
  control_t next_ctrl;
  mode_reg_t mode;
  mode_reg_t next_mode;
  word16_t rcap;
  word16_t next_rcap;
  word16_t count;
  word16_t next_count;
  logic [PW-1:0] presc;
  logic [PW-1:0] next_presc;
  logic count_prev;
  logic next_count_prev;
  logic trig_prev;
  logic next_trig_prev;
  logic [`IRQ_BITS-1:0] status;
  logic [`IRQ_BITS-1:0] next_status;
  logic [`IRQ_BITS-1:0] mask;
  logic [`IRQ_BITS-1:0] next_mask;
  logic clk_out;
  logic next_clk_out;
  logic baud_tick;
  logic next_baud_tick;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic slverr;
  logic next_slverr;

  // --------------------------------------------------------------------------
  // combinational helpers
  // --------------------------------------------------------------------------
  logic count_sync;
  logic trig_sync;
  logic count_fall;
  logic trig_fall;
  logic presc_tick;
  logic tick;
  logic up;
  logic at_top;
  logic at_bottom;
  logic wrap;
  logic hw_tf;
  logic hw_exf;
  logic exf_toggle;
  logic setup;
  logic wr;
  logic hit;
  logic [`IDX_W-1:0] idx;
  logic [7:0] wbyte;
  op_mode_t op;

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  pin_sync #(
    .RESET_LEVEL(1'b1)
  ) u_count_sync (
    .clk(CLK),
    .resetn(RESETN),
    .pin(COUNT_PIN_I),
    .level(count_sync)
  );

  pin_sync #(
    .RESET_LEVEL(1'b1)
  ) u_trig_sync (
    .clk(CLK),
    .resetn(RESETN),
    .pin(TRIG_PIN_I),
    .level(trig_sync)
  );

  assign count_fall = count_prev & ~count_sync;
  assign trig_fall = trig_prev & ~trig_sync;

  // --------------------------------------------------------------------------
  // input selection
  // --------------------------------------------------------------------------
  assign presc_tick = mode.prescaler_select | (presc == PW'(PRESCALE_DIV - 1));
  assign tick = ctrl.run_control &
    (ctrl.timer_counter_select ? count_fall : presc_tick);

  // --------------------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------------------
  always_comb
  begin
    if (ctrl.receive_clock_select | ctrl.transmit_clock_select)
      op = MODE_BAUD;
    else if (mode.clock_output_enable & ~ctrl.timer_counter_select)
      op = MODE_CLKOUT;
    else if (ctrl.capture_reload_select)
      op = MODE_CAPTURE;
    else if (mode.down_count_enable)
      op = MODE_UPDOWN;
    else
      op = MODE_RELOAD;
  end

  assign up = (op == MODE_UPDOWN) ? trig_sync : 1'b1;
  assign at_top = (count == `COUNT_TOP);
  assign at_bottom = (count == rcap);
  assign wrap = tick & (up ? at_top : at_bottom);

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  assign setup = PSEL & ~PENABLE;
  assign wr = PSEL & PENABLE & PWRITE;
  assign idx = PADDR[`APB_ADDR_W-1:2];
  assign wbyte = PWDATA[7:0];

  always_comb
  begin
    case (idx)
      `IDX_CONTROL, `IDX_MODE, `IDX_RCAP_LOW, `IDX_RCAP_HIGH: hit = 1'b1;
      `IDX_COUNT_LOW, `IDX_COUNT_HIGH, `IDX_IRQ_STATUS, `IDX_IRQ_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // counter next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_count = count;
    next_rcap = rcap;
    hw_tf = 1'b0;
    hw_exf = 1'b0;
    exf_toggle = 1'b0;
    case (op)
      MODE_CAPTURE:
      begin
        if (tick)
          next_count = word16_t'(count + 16'h0001);
        hw_tf = tick & at_top;
        if (ctrl.external_trigger_enable & trig_fall)
        begin
          next_rcap = count;
          hw_exf = 1'b1;
        end
      end
      MODE_RELOAD:
      begin
        if (tick)
          next_count = at_top ? rcap : word16_t'(count + 16'h0001);
        hw_tf = tick & at_top;
        if (ctrl.external_trigger_enable & trig_fall)
        begin
          next_count = rcap;
          hw_exf = 1'b1;
        end
      end
      MODE_UPDOWN:
      begin
        if (tick & up)
          next_count = at_top ? rcap : word16_t'(count + 16'h0001);
        else if (tick)
          next_count = at_bottom ? `COUNT_TOP : word16_t'(count - 16'h0001);
        hw_tf = wrap;
        exf_toggle = wrap;
      end
      MODE_BAUD, MODE_CLKOUT:
      begin
        if (tick)
          next_count = at_top ? rcap : word16_t'(count + 16'h0001);
        if (ctrl.external_trigger_enable & trig_fall)
          hw_exf = 1'b1;
      end
      default:
      begin
        next_count = count;
      end
    endcase
    if (wr & (idx == `IDX_COUNT_LOW))
      next_count.low = wbyte;
    if (wr & (idx == `IDX_COUNT_HIGH))
      next_count.high = wbyte;
    if (wr & (idx == `IDX_RCAP_LOW))
      next_rcap.low = wbyte;
    if (wr & (idx == `IDX_RCAP_HIGH))
      next_rcap.high = wbyte;
  end

  // --------------------------------------------------------------------------
  // register and flag next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_ctrl = ctrl;
    next_mode = mode;
    next_mask = mask;
    next_presc = presc_tick ? '0 : PW'(presc + 1'b1);
    next_count_prev = count_sync;
    next_trig_prev = trig_sync;
    if (exf_toggle)
      next_ctrl.external_event_flag = ~ctrl.external_event_flag;
    if (wr & (idx == `IDX_CONTROL))
      next_ctrl = control_t'(wbyte);
    if (wr & (idx == `IDX_MODE))
      next_mode = mode_reg_t'(wbyte & `MODE_WRITE_MASK);
    if (wr & (idx == `IDX_IRQ_MASK))
      next_mask = PWDATA[`IRQ_BITS-1:0];
    if (hw_tf)
      next_ctrl.overflow_flag = 1'b1;
    if (hw_exf)
      next_ctrl.external_event_flag = 1'b1;
    next_status = status;
    if (wr & (idx == `IDX_IRQ_STATUS))
      next_status = status & ~PWDATA[`IRQ_BITS-1:0];
    if (hw_tf)
      next_status[`IRQ_BIT_OVERFLOW] = 1'b1;
    if (hw_exf)
      next_status[`IRQ_BIT_EXTERNAL] = 1'b1;
    next_clk_out = clk_out;
    if (wrap & mode.clock_output_enable & ~ctrl.timer_counter_select)
      next_clk_out = ~clk_out;
    next_baud_tick = wrap & (op == MODE_BAUD);
  end

  // --------------------------------------------------------------------------
  // read data, latched in the setup cycle
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_rdata = rdata;
    next_slverr = slverr;
    if (setup)
    begin
      next_rdata = 32'h00000000;
      next_slverr = ~hit;
      case (idx)
        `IDX_CONTROL: next_rdata[7:0] = ctrl;
        `IDX_MODE: next_rdata[7:0] = mode;
        `IDX_RCAP_LOW: next_rdata[7:0] = rcap.low;
        `IDX_RCAP_HIGH: next_rdata[7:0] = rcap.high;
        `IDX_COUNT_LOW: next_rdata[7:0] = count.low;
        `IDX_COUNT_HIGH: next_rdata[7:0] = count.high;
        `IDX_IRQ_STATUS: next_rdata[`IRQ_BITS-1:0] = status;
        `IDX_IRQ_MASK: next_rdata[`IRQ_BITS-1:0] = mask;
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ctrl <= control_t'(`RST_CONTROL);
      mode <= mode_reg_t'(`RST_MODE);
      rcap <= {`RST_DATA, `RST_DATA};
      count <= {`RST_DATA, `RST_DATA};
      presc <= '0;
      count_prev <= 1'b1;
      trig_prev <= 1'b1;
      status <= `RST_IRQ;
      mask <= `RST_IRQ;
      clk_out <= 1'b0;
      baud_tick <= 1'b0;
      rdata <= 32'h00000000;
      slverr <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      mode <= next_mode;
      rcap <= next_rcap;
      count <= next_count;
      presc <= next_presc;
      count_prev <= next_count_prev;
      trig_prev <= next_trig_prev;
      status <= next_status;
      mask <= next_mask;
      clk_out <= next_clk_out;
      baud_tick <= next_baud_tick;
      rdata <= next_rdata;
      slverr <= next_slverr;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign PREADY = 1'b1;
  assign PRDATA = rdata;
  assign PSLVERR = slverr & PSEL & PENABLE;
  assign COUNT_PIN_O = clk_out;
  assign COUNT_PIN_OE = mode.clock_output_enable;
  assign COUNT_PIN_PULLUP = ctrl.timer_counter_select;
  assign RX_BAUD_SELECT = ctrl.receive_clock_select;
  assign TX_BAUD_SELECT = ctrl.transmit_clock_select;
  assign BAUD_TICK = baud_tick;
  assign IRQ = |(status & mask);

endmodule : timer2_control_registers

/* File: dv/timer_props.sv */
// port checks of the timer register set
// assumes binding into timer2_control_registers on one clock
`timescale 1ns/100ps
`include "timer_params.svh"
module timer_props (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`APB_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic COUNT_PIN_I,
  input wire logic COUNT_PIN_O,
  input wire logic COUNT_PIN_OE,
  input wire logic COUNT_PIN_PULLUP,
  input wire logic TRIG_PIN_I,
  input wire logic RX_BAUD_SELECT,
  input wire logic TX_BAUD_SELECT,
  input wire logic BAUD_TICK,
  input wire logic IRQ
);
  // ------
  // sequences
  // ------
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence acc; PSEL && PENABLE; endsequence
  sequence ctl_wr; acc ##0 PWRITE && PADDR[11:2] == `IDX_CONTROL; endsequence
  sequence mode_wr; acc ##0 PWRITE && PADDR[11:2] == `IDX_MODE; endsequence
  sequence mask_off; acc ##0 PWRITE && PADDR[11:2] == `IDX_IRQ_MASK && PWDATA[1:0] == 2'h0;
  endsequence
  // ------
  // assertions
  // ------
  AST_RX_SEL: assert property (ctl_wr |=> RX_BAUD_SELECT == $past(PWDATA[5]))
    else $error("receive select differs from written bit");
  AST_TX_SEL: assert property (ctl_wr |=> TX_BAUD_SELECT == $past(PWDATA[4]))
    else $error("transmit select differs from written bit");
  AST_PULLUP: assert property (ctl_wr |=> COUNT_PIN_PULLUP == $past(PWDATA[1]))
    else $error("pull-up differs from counter select");
  AST_OUT_EN: assert property (mode_wr |=> COUNT_PIN_OE == $past(PWDATA[1]))
    else $error("pin enable differs from written bit");
  AST_RESET: assert property ($rose(RESETN) |-> PREADY && !(IRQ || BAUD_TICK || COUNT_PIN_O
    || COUNT_PIN_OE || COUNT_PIN_PULLUP || RX_BAUD_SELECT || TX_BAUD_SELECT))
    else $error("outputs not cleared by reset");
  AST_BAUD: assert property (BAUD_TICK |-> $past(RX_BAUD_SELECT || TX_BAUD_SELECT)
    || $past(RX_BAUD_SELECT || TX_BAUD_SELECT, 2))
    else $error("baud tick outside baud mode");
  AST_CLK_OUT: assert property ($changed(COUNT_PIN_O) |-> $past(COUNT_PIN_OE)
    || $past(COUNT_PIN_OE, 2))
    else $error("clock output moved while disabled");
  AST_MASK: assert property (mask_off |=> !IRQ [*3])
    else $error("interrupt high with all masked");
  AST_RD_BYTE: assert property (acc ##0 !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule : timer_props

bind timer2_control_registers timer_props i_props (
  .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .COUNT_PIN_I(COUNT_PIN_I), .COUNT_PIN_O(COUNT_PIN_O), .COUNT_PIN_OE(COUNT_PIN_OE),
  .COUNT_PIN_PULLUP(COUNT_PIN_PULLUP), .TRIG_PIN_I(TRIG_PIN_I),
  .RX_BAUD_SELECT(RX_BAUD_SELECT), .TX_BAUD_SELECT(TX_BAUD_SELECT),
  .BAUD_TICK(BAUD_TICK), .IRQ(IRQ));

/* File: dv/pin_model.sv */
// external pins: count pin source with pull-up, trigger/direction pin
// assumes the design drives the count pin only while its enable is high
`timescale 1ns/100ps
module pin_model (
  input wire logic clk,
  input wire logic count_o,
  input wire logic count_oe,
  input wire logic pull_en,
  output logic count_i,
  output logic trig_i
);
  logic drv = 1'b0;
  logic val = 1'b1;
  logic alt = 1'b0;
  logic trig = 1'b1;
  // released pin without pull-up wanders
  always @(posedge clk) alt <= ~alt;
  assign count_i = count_oe ? count_o : drv ? val : pull_en ? 1'b1 : alt;
  assign trig_i = trig;
  task pulse(input int n);
    repeat (n)
    begin
      @(posedge clk);
      drv <= 1'b1;
      val <= 1'b0;
      repeat (4) @(posedge clk);
      val <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask : pulse
  task trigger(input logic v);
    @(posedge clk);
    trig <= v;
  endtask : trigger
endmodule : pin_model

/* File: dv/tb.sv */
// self-checking bench of the timer register set over apb
// assumes pin_model on the pins and timer_props bound into the design
`timescale 1ns/100ps
`include "timer_params.svh"
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, r;
  logic pready, pslverr, cnt_i, cnt_o, cnt_oe, pull_on, trig_i, rxs, txs, btick, irq, slv;
  int n_errors = 0;
  int compares = 0;
  localparam logic [9:0] ctl = `IDX_CONTROL;
  localparam logic [9:0] mode = `IDX_MODE;
  localparam logic [9:0] rl = `IDX_RCAP_LOW;
  localparam logic [9:0] rh = `IDX_RCAP_HIGH;
  localparam logic [9:0] cl = `IDX_COUNT_LOW;
  localparam logic [9:0] ch = `IDX_COUNT_HIGH;
  localparam logic [9:0] ist = `IDX_IRQ_STATUS;
  localparam logic [9:0] imk = `IDX_IRQ_MASK;
  localparam logic [9:0] regs [8] = '{ctl, mode, rl, rh, cl, ch, ist, imk};
  always #5 clk = ~clk;
  timer2_control_registers i_dut (
    .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .COUNT_PIN_I(cnt_i), .COUNT_PIN_O(cnt_o), .COUNT_PIN_OE(cnt_oe),
    .COUNT_PIN_PULLUP(pull_on), .TRIG_PIN_I(trig_i), .RX_BAUD_SELECT(rxs),
    .TX_BAUD_SELECT(txs), .BAUD_TICK(btick), .IRQ(irq));
  pin_model i_pin (.clk(clk), .count_o(cnt_o), .count_oe(cnt_oe), .pull_en(pull_on),
    .count_i(cnt_i), .trig_i(trig_i));
  // ------
  // bus and compare tasks
  // ------
  task apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++t < 50);
    r = prdata;
    slv = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask : chk
  task wr(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask : wr
  task rc(input logic [9:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    chk($sformatf("register %h", i), e, r);
  endtask : rc
  task pins(input logic [6:0] e);
    @(negedge clk);
    chk("pins", {25'h0, e}, {25'h0, irq, btick, cnt_o, cnt_oe, pull_on, rxs, txs});
  endtask : pins
  task edges(input logic sel, input logic [31:0] e);
    logic [31:0] n;
    logic p, v;
    n = 0;
    repeat (4) @(posedge clk);
    p = sel ? cnt_o : btick;
    repeat (20)
    begin
      @(posedge clk);
      v = sel ? cnt_o : btick;
      n = n + (v !== p);
      p = v;
    end
    chk("edges", e, n);
  endtask : edges
  task summarize;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // ------
  // scenarios
  // ------
  task t_regs;
    for (int k = 0; k < 8; k++) rc(regs[k], 32'h0);
    pins(7'h00);
    for (int k = 2; k < 6; k++)
    begin
      wr(regs[k], 32'hffffff3c + k);
      rc(regs[k], 32'h3c + k);
    end
    wr(mode, 32'hff);
    rc(mode, 32'h83);
    apb(1'b0, 10'h0c0, 32'h0);
    chk("unmapped", 32'h1, {r[30:0], slv});
  endtask : t_regs
  task t_run;
    wr(mode, 32'h80);
    wr(cl, 32'h0);
    wr(ch, 32'h0);
    wr(ctl, 32'h04);
    repeat (6) @(posedge clk);
    wr(ctl, 32'h00);
    repeat (20) @(posedge clk);
    rc(cl, 32'h09);
    wr(mode, 32'h00);
    wr(cl, 32'h0);
    wr(ctl, 32'h04);
    repeat (58) @(posedge clk);
    wr(ctl, 32'h00);
    rc(cl, 32'h05);
  endtask : t_run
  task t_reload;
    wr(mode, 32'h80);
    wr(rl, 32'h34);
    wr(rh, 32'h12);
    wr(cl, 32'hfe);
    wr(ch, 32'hff);
    wr(imk, 32'h1);
    wr(ctl, 32'h04);
    wr(ctl, 32'h80);
    rc(cl, 32'h35);
    rc(ch, 32'h12);
    rc(ctl, 32'h80);
    rc(ist, 32'h1);
    pins(7'h40);
    wr(imk, 32'h0);
    pins(7'h00);
    wr(imk, 32'h1);
    pins(7'h40);
    wr(ist, 32'h1);
    pins(7'h00);
    rc(ist, 32'h0);
    wr(ctl, 32'h40);
    rc(ctl, 32'h40);
    wr(ctl, 32'h00);
    rc(ctl, 32'h00);
  endtask : t_reload
  task t_capture;
    wr(cl, 32'hcd);
    wr(ch, 32'hab);
    wr(ctl, 32'h09);
    i_pin.trigger(1'b0);
    repeat (5) @(posedge clk);
    rc(rl, 32'hcd);
    rc(rh, 32'hab);
    rc(ctl, 32'h49);
    rc(ist, 32'h2);
    wr(ist, 32'h3);
    wr(ctl, 32'h00);
    i_pin.trigger(1'b1);
  endtask : t_capture
  task t_counter;
    wr(ctl, 32'h02);
    pins(7'h04);
    wr(cl, 32'h0);
    wr(ch, 32'h0);
    wr(ctl, 32'h06);
    i_pin.pulse(3);
    wr(ctl, 32'h00);
    rc(cl, 32'h03);
  endtask : t_counter
  task t_updown;
    i_pin.trigger(1'b0);
    wr(mode, 32'h81);
    wr(rl, 32'h10);
    wr(rh, 32'h00);
    for (int k = 0; k < 2; k++)
    begin
      wr(cl, k ? 32'hfe : 32'h10);
      wr(ch, k ? 32'hff : 32'h00);
      wr(ctl, 32'h04);
      wr(ctl, 32'h00);
      rc(cl, k ? 32'h11 : 32'hfd);
      rc(ch, k ? 32'h00 : 32'hff);
      rc(ist, 32'h1);
      wr(ist, 32'h3);
      i_pin.trigger(1'b1);
    end
  endtask : t_updown
  task t_baud;
    wr(mode, 32'h80);
    wr(rl, 32'hfe);
    wr(rh, 32'hff);
    wr(cl, 32'hfe);
    wr(ch, 32'hff);
    wr(ctl, 32'h24);
    edges(1'b0, 32'd20);
    wr(ctl, 32'h14);
    edges(1'b0, 32'd20);
    wr(ctl, 32'h10);
    rc(ctl, 32'h10);
    pins(7'h01);
    wr(ctl, 32'h00);
    rc(ist, 32'h0);
    wr(mode, 32'h82);
    wr(ctl, 32'h04);
    edges(1'b1, 32'd10);
    wr(ctl, 32'h00);
    pins({2'b00, cnt_o, 4'h8});
    wr(mode, 32'h80);
    pins({2'b00, cnt_o, 4'h0});
  endtask : t_baud
  task t_reset;
    wr(mode, 32'h83);
    wr(ctl, 32'h3e);
    wr(imk, 32'h3);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    for (int k = 0; k < 8; k++) rc(regs[k], 32'h0);
    pins(7'h00);
  endtask : t_reset
  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_run;
    t_reload;
    t_capture;
    t_counter;
    t_updown;
    t_baud;
    t_reset;
    summarize;
  end
  initial
  begin
    #200000;
    $display("Error watchdog expected finish seen timeout");
    n_errors++;
    summarize;
  end
endmodule : tb
